//--- tcc_timer.sv
`timescale 1ns/100ps
// Contract
// - prescaler gives seven rates for counter
// - three-bit field selects prescaler rate
// - active capture edge latches counter value
// - capture edge polarity programmable per channel
// - capture event may raise interrupt
// - compare match sets, clears or toggles pin
// - compare match may raise interrupt
// - value writes take effect immediately
// - compare only when counter reaches value
// - interrupts raised after capture, match or wrap
// - toggle-on-wrap bit toggles pin at overflow in compare mode
module tcc_timer #(
  parameter int NCHAN = 2 // Channel count
) (
  input wire logic mclk, // Bus clock, 100 MHz
  input wire logic reset, // Sync reset, high
  input wire logic [3:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic [NCHAN-1:0] pin_in, // Channel pin levels
  output logic [NCHAN-1:0] pin_out, // Channel pin drive
  output logic [NCHAN-1:0] pin_oe_n, // Low while driving
  output logic irq // Level interrupt
);
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [15:0] modulo;
  logic [15:0] next_modulo;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] next_rdata;
  logic tick;
  logic wrap;
  tcc_pkg::tcc_chan_cfg_t cfg [NCHAN];
  tcc_pkg::tcc_chan_cfg_t next_cfg [NCHAN];
  logic [15:0] value [NCHAN];
  logic [NCHAN-1:0] event_pulse;
  logic [NCHAN-1:0] wr_high;
  logic [NCHAN-1:0] wr_low;

  tcc_prescaler u_prescaler (
    .mclk(mclk),
    .reset(reset),
    .clear(wr && addr == tcc_pkg::ADDR_TIMER_CTRL && wdata[tcc_pkg::CLR_BIT]),
    .run(~ctrl[tcc_pkg::STOP_BIT]),
    .prescale_select(ctrl[tcc_pkg::PS_LSB +: 3]),
    .tick(tick)
  );

  // Wrap after modulo value reached
  assign wrap = tick && count == modulo;

  // Per-channel instances; channel registers sit three apart
  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    localparam logic [3:0] BASE = 4'(tcc_pkg::ADDR_CH0_CTRL + 3 * c);
    assign wr_high[c] = wr && addr == 4'(BASE + 4'h1);
    assign wr_low[c] = wr && addr == 4'(BASE + 4'h2);
    tcc_channel u_chan (
      .mclk(mclk),
      .reset(reset),
      .cfg(cfg[c]),
      .count(count),
      .tick(tick),
      .wrap(wrap),
      .pin_in(pin_in[c]),
      .wr_high(wr_high[c]),
      .wr_low(wr_low[c]),
      .wdata(wdata),
      .value(value[c]),
      .pin_out(pin_out[c]),
      .pin_oe_n(pin_oe_n[c]),
      .event_pulse(event_pulse[c])
    );
  end

  // Counter, control and channel setup
  always_comb begin
    next_count = count;
    next_ctrl = ctrl;
    next_modulo = modulo;
    next_mask = mask;
    next_cfg = cfg;
    if (wrap) begin
      next_count = 16'h0000;
    end else if (tick) begin
      next_count = 16'(count + 16'h0001);
    end
    if (wr) begin
      if (addr == tcc_pkg::ADDR_TIMER_CTRL) begin
        next_ctrl = wdata & 8'h27; // Clear bit self-clears
        if (wdata[tcc_pkg::CLR_BIT]) begin
          next_count = 16'h0000;
        end
      end else if (addr == tcc_pkg::ADDR_MOD_HIGH) begin
        next_modulo[15:8] = wdata;
      end else if (addr == tcc_pkg::ADDR_MOD_LOW) begin
        next_modulo[7:0] = wdata;
      end else if (addr == tcc_pkg::ADDR_IRQ_MASK) begin
        next_mask = wdata;
      end
      for (int c = 0; c < NCHAN; c++) begin
        if (addr == 4'(tcc_pkg::ADDR_CH0_CTRL + 3 * c)) begin
          next_cfg[c].irq_enable = wdata[tcc_pkg::IE_BIT];
          next_cfg[c].mode_select_a = wdata[tcc_pkg::MSA_BIT];
          next_cfg[c].edge_level_b = wdata[tcc_pkg::ELSB_BIT];
          next_cfg[c].edge_level_a = wdata[tcc_pkg::ELSA_BIT];
          next_cfg[c].toggle_on_wrap = wdata[tcc_pkg::TOV_BIT];
        end
      end
    end
  end

  // Sticky status: read clears, but a same-cycle event wins
  always_comb begin
    next_status = status;
    if (rd && addr == tcc_pkg::ADDR_IRQ_STATUS) begin
      next_status = 8'h00;
    end
    for (int c = 0; c < NCHAN; c++) begin
      if (event_pulse[c] && cfg[c].irq_enable) begin
        next_status[tcc_pkg::IRQ_CH0 + c] = 1'b1;
      end
    end
    if (wrap) begin
      next_status[tcc_pkg::IRQ_WRAP] = 1'b1;
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      if (addr == tcc_pkg::ADDR_TIMER_CTRL) begin
        next_rdata = ctrl;
      end else if (addr == tcc_pkg::ADDR_MOD_HIGH) begin
        next_rdata = modulo[15:8];
      end else if (addr == tcc_pkg::ADDR_MOD_LOW) begin
        next_rdata = modulo[7:0];
      end else if (addr == tcc_pkg::ADDR_CNT_HIGH) begin
        next_rdata = count[15:8];
      end else if (addr == tcc_pkg::ADDR_CNT_LOW) begin
        next_rdata = count[7:0];
      end else if (addr == tcc_pkg::ADDR_IRQ_STATUS) begin
        next_rdata = status;
      end else if (addr == tcc_pkg::ADDR_IRQ_MASK) begin
        next_rdata = mask;
      end
      for (int c = 0; c < NCHAN; c++) begin
        if (addr == 4'(tcc_pkg::ADDR_CH0_CTRL + 3 * c)) begin
          next_rdata = {status[tcc_pkg::IRQ_CH0 + c], cfg[c].irq_enable, 1'b0,
                        cfg[c].mode_select_a, cfg[c].edge_level_b,
                        cfg[c].edge_level_a, 1'b0, cfg[c].toggle_on_wrap};
        end else if (addr == 4'(tcc_pkg::ADDR_CH0_HIGH + 3 * c)) begin
          next_rdata = value[c][15:8];
        end else if (addr == 4'(tcc_pkg::ADDR_CH0_LOW + 3 * c)) begin
          next_rdata = value[c][7:0];
        end
      end
    end
  end

  assign irq = |(status & mask);

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= tcc_pkg::CTRL_RESET;
      modulo <= tcc_pkg::MOD_RESET;
      count <= 16'h0000;
      mask <= tcc_pkg::MASK_RESET;
      status <= 8'h00;
      rdata <= 8'h00;
      for (int c = 0; c < NCHAN; c++) begin
        cfg[c] <= '0;
      end
    end else begin
      ctrl <= next_ctrl;
      modulo <= next_modulo;
      count <= next_count;
      mask <= next_mask;
      status <= next_status;
      rdata <= next_rdata;
      cfg <= next_cfg;
    end
  end
endmodule

//--- tcc_pkg.sv
package tcc_pkg;
  // Register indices (word index, byte address = index * 4)
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MOD_HIGH = 4'h1;
  localparam logic [3:0] ADDR_MOD_LOW = 4'h2;
  localparam logic [3:0] ADDR_CNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CNT_LOW = 4'h4;
  localparam logic [3:0] ADDR_CH0_CTRL = 4'h5;
  localparam logic [3:0] ADDR_CH0_HIGH = 4'h6;
  localparam logic [3:0] ADDR_CH0_LOW = 4'h7;
  localparam logic [3:0] ADDR_CH1_CTRL = 4'h8;
  localparam logic [3:0] ADDR_CH1_HIGH = 4'h9;
  localparam logic [3:0] ADDR_CH1_LOW = 4'hA;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hB;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  // Timer control fields
  localparam int PS_LSB = 0;
  localparam int STOP_BIT = 5;
  localparam int CLR_BIT = 4;
  // Channel control fields
  localparam int TOV_BIT = 0;
  localparam int ELSA_BIT = 2;
  localparam int ELSB_BIT = 3;
  localparam int MSA_BIT = 4;
  localparam int IE_BIT = 6;
  localparam int FLAG_BIT = 7;
  // Interrupt status layout
  localparam int IRQ_CH0 = 0;
  localparam int IRQ_CH1 = 1;
  localparam int IRQ_WRAP = 2;
  // Reset values and prescaler rate count
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int PRESCALE_RATES = 7;
  // Per-channel configuration
  typedef struct packed {
    logic irq_enable;
    logic mode_select_a;
    logic edge_level_b;
    logic edge_level_a;
    logic toggle_on_wrap;
  } tcc_chan_cfg_t;
  // Edge/action decode
  typedef enum logic [1:0] {
    TCC_ACT_NONE = 2'b00,
    TCC_ACT_TOGGLE = 2'b01,
    TCC_ACT_CLEAR = 2'b10,
    TCC_ACT_SET = 2'b11
  } tcc_action_t;
endpackage

//--- tcc_prescaler.sv
`timescale 1ns/100ps
module tcc_prescaler (
  input wire logic mclk, // Bus clock
  input wire logic reset, // Sync reset, high
  input wire logic clear, // Restart divider
  input wire logic run, // Divider enabled
  input wire logic [2:0] prescale_select, // Rate choice
  output logic tick // One-cycle count pulse
);
  logic [5:0] div;
  logic [5:0] next_div;
  logic sel_bit;

  // Free divider; rate 2^sel, sel above six saturates at six
  always_comb begin
    next_div = div;
    if (clear) begin
      next_div = 6'h00;
    end else if (run) begin
      next_div = div + 6'h01;
    end
  end

  // Tick when low sel bits of divider all ones
  always_comb begin
    sel_bit = 1'b1;
    for (int i = 0; i < tcc_pkg::PRESCALE_RATES - 1; i++) begin
      if (i < int'(prescale_select)) begin
        sel_bit = sel_bit & div[i];
      end
    end
    tick = run & ~clear & sel_bit;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      div <= 6'h00;
    end else begin
      div <= next_div;
    end
  end
endmodule

//--- tcc_channel.sv
`timescale 1ns/100ps
module tcc_channel (
  input wire logic mclk, // Bus clock
  input wire logic reset, // Sync reset, high
  input wire tcc_pkg::tcc_chan_cfg_t cfg, // Channel setup
  input wire logic [15:0] count, // Counter value
  input wire logic tick, // Counter advance
  input wire logic wrap, // Counter overflow pulse
  input wire logic pin_in, // Pin level
  input wire logic wr_high, // Value high byte write
  input wire logic wr_low, // Value low byte write
  input wire logic [7:0] wdata, // Write byte
  output logic [15:0] value, // Value pair
  output logic pin_out, // Pin drive level
  output logic pin_oe_n, // Low while driving
  output logic event_pulse // Capture or match
);
  logic [15:0] next_value;
  logic next_pin_out;
  logic pin_last;
  logic edge_hit;
  logic match;
  tcc_pkg::tcc_action_t act;

  assign act = tcc_pkg::tcc_action_t'({cfg.edge_level_b, cfg.edge_level_a});

  // Active edge decode: 01 rise, 10 fall, 11 both
  always_comb begin
    case (act)
      tcc_pkg::TCC_ACT_TOGGLE: edge_hit = pin_in & ~pin_last;
      tcc_pkg::TCC_ACT_CLEAR: edge_hit = ~pin_in & pin_last;
      tcc_pkg::TCC_ACT_SET: edge_hit = pin_in ^ pin_last;
      default: edge_hit = 1'b0;
    endcase
  end

  // Match only as counter lands on the value; passed values miss
  assign match = tick & (count == value);
  assign event_pulse = cfg.mode_select_a ? match : edge_hit;
  assign pin_oe_n = ~(cfg.mode_select_a && act != tcc_pkg::TCC_ACT_NONE);

  // Value pair and pin next state
  always_comb begin
    next_value = value;
    next_pin_out = pin_out;
    if (wr_high) begin
      next_value[15:8] = wdata;
    end else if (wr_low) begin
      next_value[7:0] = wdata;
    end
    if (!cfg.mode_select_a && edge_hit) begin
      next_value = count;
    end
    if (cfg.mode_select_a) begin
      if (wrap && cfg.toggle_on_wrap) begin
        next_pin_out = ~pin_out;
      end
      if (match) begin
        case (act)
          tcc_pkg::TCC_ACT_TOGGLE: next_pin_out = ~next_pin_out;
          tcc_pkg::TCC_ACT_CLEAR: next_pin_out = 1'b0;
          tcc_pkg::TCC_ACT_SET: next_pin_out = 1'b1;
          default: next_pin_out = next_pin_out;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      value <= 16'h0000;
      pin_out <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      value <= next_value;
      pin_out <= next_pin_out;
      pin_last <= pin_in;
    end
  end
endmodule

//--- tcc_pin_model.sv
`timescale 1ns/100ps
// Far side of the pins: event sources, or a load on a driven pin
module tcc_pin_model #(
  parameter int NCHAN = 2 // Channel count
) (
  input wire logic [NCHAN-1:0] src, // Event source levels
  input wire logic [NCHAN-1:0] pin_out, // Timer drive level
  input wire logic [NCHAN-1:0] pin_oe_n, // Low while timer drives
  output logic [NCHAN-1:0] pin_in // Wire level
);
  // A driven pin reads back its own level, so no fight on the wire
  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      pin_in[i] = pin_oe_n[i] ? src[i] : pin_out[i];
    end
  end
endmodule

//--- tcc_timer_assertions.sv
`timescale 1ns/100ps
module tcc_timer_assertions #(
  parameter int NCHAN = 2 // Channel count
) (
  input wire logic mclk, // Bus clock
  input wire logic reset, // Sync reset
  input wire logic [3:0] addr, // Index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic [NCHAN-1:0] pin_in, // Pin levels
  input wire logic [NCHAN-1:0] pin_out, // Pin drive
  input wire logic [NCHAN-1:0] pin_oe_n, // Drive enable
  input wire logic irq // Interrupt
);
  logic stop_q;
  logic mask_zero;
  logic next_stop_q;
  logic next_mask_zero;
  // Shadows of stop bit and mask, seen from bus writes only
  always_comb begin
    next_stop_q = stop_q;
    next_mask_zero = mask_zero;
    if (wr && addr == tcc_pkg::ADDR_TIMER_CTRL) next_stop_q = wdata[tcc_pkg::STOP_BIT];
    if (wr && addr == tcc_pkg::ADDR_IRQ_MASK) next_mask_zero = (wdata == 8'h00);
  end
  always_ff @(posedge mclk) begin
    stop_q <= reset ? 1'b0 : next_stop_q;
    mask_zero <= reset ? 1'b1 : next_mask_zero;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  AST_RESET_OUT: assert property ($past(reset) |-> pin_out == '0 && pin_oe_n == '1 && !irq)
    else $error("outputs not at reset level");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data without read");
  AST_UNMAPPED: assert property (rd && addr > 4'hC |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CH0_DRIVE: assert property (wr && addr == tcc_pkg::ADDR_CH0_CTRL && wdata[4]
    && wdata[3:2] != 2'b00 |=> !pin_oe_n[0])
    else $error("compare pin not driven");
  AST_CH1_INPUT: assert property (wr && addr == tcc_pkg::ADDR_CH1_CTRL && !wdata[4]
    |=> pin_oe_n[1])
    else $error("capture pin driven");
  AST_MASKED: assert property (mask_zero |-> !irq)
    else $error("irq with mask clear");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr) || $past(reset)
    || $past(rd && addr == tcc_pkg::ADDR_IRQ_STATUS))
    else $error("irq dropped without cause");
  AST_STOP_HOLD: assert property (stop_q && $past(stop_q, 3) && !$past(wr)
    && !$past(wr, 2) |-> $stable(pin_out))
    else $error("pin moved with counter stopped");
endmodule
bind tcc_timer tcc_timer_assertions #(.NCHAN(NCHAN)) u_chk (.mclk(mclk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));

//--- tb.sv
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] src = 2'b00;
  logic [7:0] rdata;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  logic irq;
  logic [7:0] d;
  logic [15:0] c;
  logic [15:0] c1;
  logic [15:0] c2;
  logic exp_pin;
  logic [7:0] nv;
  logic [7:0] lv;
  int n_errors = 0;
  int tests_run = 0;
  integer seed = 32'h5755;
  time t0;
  tcc_timer #(.NCHAN(2)) uut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq));
  tcc_pin_model #(.NCHAN(2)) u_pins (.src(src), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));
  // 100 MHz bus clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bus cycles: strobe held one cycle, read data taken in the cycle after
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rreg(a, v[15:8]);
    rreg(a + 4'h1, v[7:0]);
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_irq();
    for (int n = 0; irq !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
      if (n > 3000) begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask
  // Stop the counter and read where it stands
  task automatic stop_read(output logic [15:0] v);
    wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h20);
    rd16(tcc_pkg::ADDR_CNT_HIGH, v);
  endtask
  // Run a random stretch at full rate, then stop and read the counter
  task automatic run_stop(output logic [15:0] v);
    wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h00);
    repeat (4 + ($random(seed) & 31)) @(posedge mclk);
    stop_read(v);
  endtask
  // Wrap period in cycles for modulo 3; the two slowest rates are equal
  function automatic int period(input int ps);
    return 4 << ((ps > 6) ? 6 : ps);
  endfunction
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rreg(tcc_pkg::ADDR_CH1_CTRL, d);
    chk({8'h00, d}, 16'h0000);
    wreg(tcc_pkg::ADDR_MOD_HIGH, 8'h00);
    wreg(tcc_pkg::ADDR_MOD_LOW, 8'h03);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h04);
    for (int ps = 0; ps < 8; ps++) begin
      wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h10 | 8'(ps));
      rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
      wait_irq();
      t0 = $time;
      rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
      wait_irq();
      chk(16'(($time - t0) / 10), 16'(period(ps)));
    end
    $display("rates done");
    // Capture: rising and falling by turns, both edges in the last two passes
    wreg(tcc_pkg::ADDR_MOD_HIGH, 8'hFF);
    wreg(tcc_pkg::ADDR_MOD_LOW, 8'hFF);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h01);
    wreg(tcc_pkg::ADDR_CH1_CTRL, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wreg(tcc_pkg::ADDR_CH0_CTRL, (k > 3) ? 8'h4C : k[0] ? 8'h48 : 8'h44);
      rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
      run_stop(c1);
      @(posedge mclk) src[0] <= ~src[0];
      run_stop(c2);
      @(posedge mclk) src[0] <= ~src[0];
      repeat (4) @(posedge mclk);
      rd16(tcc_pkg::ADDR_CH0_HIGH, c);
      chk(c, (k[0] || k > 3) ? c2 : c1);
      rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
      chk({8'h00, d}, 16'h0001);
    end
    $display("capture done");
    // Compare at 5 in a period of 10: toggle plus wrap toggle, set, clear, toggle
    wreg(tcc_pkg::ADDR_MOD_LOW, 8'h09);
    wreg(tcc_pkg::ADDR_MOD_HIGH, 8'h00);
    wreg(tcc_pkg::ADDR_CH1_HIGH, 8'h00);
    wreg(tcc_pkg::ADDR_CH1_LOW, 8'h05);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h02);
    exp_pin = 1'b0;
    for (int a = 4; a > 0; a--) begin
      wreg(tcc_pkg::ADDR_CH1_CTRL, (a == 4) ? 8'h55 : 8'h50 | 8'(a << 2));
      if (a == 4) wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h04);
      wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h30);
      rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
      if (a == 3) wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h02);
      wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h00);
      wait_irq();
      wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h20);
      exp_pin = (a == 4 || a == 2) ? 1'b0 : (a == 3) ? 1'b1 : ~exp_pin;
      #1 chk({15'h0000, pin_out[1]}, {15'h0000, exp_pin});
    end
    chk({15'h0000, pin_oe_n[1]}, 16'h0000);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h00);
    #1 chk({15'h0000, irq}, 16'h0000);
    $display("compare modes done");
    // Service-time updates: shrink after a compare, grow after a wrap
    wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h30);
    wreg(tcc_pkg::ADDR_MOD_LOW, 8'h40);
    wreg(tcc_pkg::ADDR_CH1_LOW, 8'h30);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h02);
    nv = 8'h08 | 8'($random(seed) & 31);
    lv = 8'h30 | 8'($random(seed) & 7);
    rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
    wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h00);
    wait_irq();
    wreg(tcc_pkg::ADDR_CH1_LOW, nv);
    rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
    wait_irq();
    // Stop lands three counts after the matching one
    stop_read(c);
    chk(c, 16'(nv) + 16'h0003);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h04);
    rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
    wreg(tcc_pkg::ADDR_TIMER_CTRL, 8'h00);
    wait_irq();
    wreg(tcc_pkg::ADDR_CH1_LOW, lv);
    wreg(tcc_pkg::ADDR_IRQ_MASK, 8'h02);
    rreg(tcc_pkg::ADDR_IRQ_STATUS, d);
    wait_irq();
    stop_read(c);
    chk(c, 16'(lv) + 16'h0003);
    $display("service updates done");
    wreg(tcc_pkg::ADDR_CH0_CTRL, 8'h1C);
    rreg(4'hD, d);
    chk({8'h00, d}, 16'h0000);
    $display("compare done");
    tally_and_finish();
  end
endmodule
